// [inc/conv_regs_pkg.sv]
// Purpose: shared constants and carriers for the converter status, interrupt and lock registers
// Assumes: 8-bit register addresses and data, internal register port
// Notes:   converter_flags offset is not printed in the map, so it is a chosen constant
package conv_regs_pkg;

    localparam logic [7:0] CONVERTER_FLAGS_ADDR   = 8'h05;
    localparam logic [7:0] INTERRUPT_FLAGS_ADDR   = 8'h06;
    localparam logic [7:0] INTERRUPT_MASKS_ADDR   = 8'h07;
    localparam logic [7:0] LOCK_PART_MASK_ADDR    = 8'h50;
    localparam logic [7:0] LOCK_PASSWORD_ADDR     = 8'h51;
    localparam logic [7:0] VOLTAGE_SETTING_ADDR   = 8'h02;

    localparam int         INPUT_LOW_BIT          = 0;
    localparam int         OUTPUT_OK_BIT          = 1;
    localparam int         LOCK_MASK_BIT          = 0;

    localparam logic [1:0] IRQ_MASK_RESET         = 2'h0;
    localparam logic       LOCK_MASK_RESET        = 1'h1;
    localparam logic [7:0] LOCK_CODE_RESET        = 8'hFF;
    localparam logic [7:0] LOCK_CODE_LOCK         = 8'hAA;
    localparam logic [7:0] LOCK_CODE_UNLOCK       = 8'h55;
    localparam logic [7:0] VOLTAGE_SETTING_RESET  = 8'h00;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic       output_ok;
        logic       input_low;
    } conv_cond_t;

endpackage

// [hdl/cond_flag.sv]
// Purpose: one condition flag following its analog comparator level
// Assumes: level synchronous to core_clk_in
// Notes:   used for both status and interrupt flag bits
`timescale 1ns/1ps
module cond_flag (
    input  wire logic core_clk_in,
    input  wire logic reset_in,
    input  wire logic clk_en_in,
    input  wire logic level_in,
    output logic      flag_out
);
    typedef struct packed {
        logic flag;
    } flag_state_t;

    flag_state_t state_q;
    flag_state_t state_d;

    always_comb begin
        state_d      = state_q;
        state_d.flag = level_in;
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            state_q <= '0;
        end else if (clk_en_in) begin
            state_q <= state_d;
        end
    end

    assign flag_out = state_q.flag;
endmodule

// [hdl/converter_status_irq_lock_regs.sv]
// Purpose: status, interrupt, mask, lock-mask and password registers of a buck-boost converter
// Assumes: single-cycle register port from the serial interface, all inputs synchronous
// Notes:   reads answer combinationally into a registered data word one cycle later
// Function
// [R01] status bit 1 reads 1 when output can deliver full power
// [R02] status bit 0 reads 1 when input is low and power may be limited
// [R03] interrupt bit 1, read-only, reads 1 while output is in regulation
// [R04] interrupt bit 0, read-only, reads 1 while input is too low
// [R05] mask register bits 1 and 0 mask their interrupts, reset to 0
// [R06] lock-mask bit resets to 1; 1 excludes converter registers from locking
// [R07] password 0xAA locks the voltage setting register; password resets to 0xFF
// [R08] password 0x55 unlocks; voltage setting then accepts writes
// [R09] reserved bits read zero and ignore writes
// [R10] interrupt output asserts only for a set, unmasked flag
`timescale 1ns/1ps
module converter_status_irq_lock_regs (
    input  wire logic                    core_clk_in,
    input  wire logic                    reset_in,
    input  wire logic                    clk_en_in,
    input  wire conv_regs_pkg::reg_req_t req_in,
    input  wire conv_regs_pkg::conv_cond_t cond_in,
    output logic [7:0]                   rdata_out,
    output logic                         rvalid_out,
    output logic [7:0]                   voltage_setting_out,
    output logic                         voltage_locked_out,
    output logic                         irq_n_out
);
    typedef struct packed {
        logic [1:0] irq_mask;
        logic       lock_mask;
        logic [7:0] lock_code;
        logic       locked;
        logic [7:0] voltage_setting;
        logic [7:0] rdata;
        logic       rvalid;
        logic       irq_n;
    } regs_state_t;

    regs_state_t state_q;
    regs_state_t state_d;
    logic        output_ok_flag;
    logic        input_low_flag;
    logic        output_ok_irq;
    logic        input_low_irq;

    // status and interrupt views share the same condition; flags track the level
    cond_flag u_ok_flag (
        .core_clk_in (core_clk_in),
        .reset_in    (reset_in),
        .clk_en_in   (clk_en_in),
        .level_in    (cond_in.output_ok),
        .flag_out    (output_ok_flag)
    );

    cond_flag u_low_flag (
        .core_clk_in (core_clk_in),
        .reset_in    (reset_in),
        .clk_en_in   (clk_en_in),
        .level_in    (cond_in.input_low),
        .flag_out    (input_low_flag)
    );

    assign output_ok_irq = output_ok_flag; // [R03]
    assign input_low_irq = input_low_flag; // [R04]

    always_comb begin
        state_d        = state_q;
        state_d.rvalid = 1'b0;
        state_d.irq_n  = !((output_ok_irq && !state_q.irq_mask[conv_regs_pkg::OUTPUT_OK_BIT]) ||
                           (input_low_irq && !state_q.irq_mask[conv_regs_pkg::INPUT_LOW_BIT])); // [R10]
        if (req_in.wr) begin
            unique case (req_in.addr)
                conv_regs_pkg::INTERRUPT_MASKS_ADDR: begin
                    state_d.irq_mask = req_in.wdata[1:0]; // [R05] [R09]
                end
                conv_regs_pkg::LOCK_PART_MASK_ADDR: begin
                    state_d.lock_mask = req_in.wdata[conv_regs_pkg::LOCK_MASK_BIT]; // [R06] [R09]
                end
                conv_regs_pkg::LOCK_PASSWORD_ADDR: begin
                    state_d.lock_code = req_in.wdata;
                    // codes act only while the converter registers take part in locking
                    if (!state_q.lock_mask && req_in.wdata == conv_regs_pkg::LOCK_CODE_LOCK) begin
                        state_d.locked = 1'b1; // [R06] [R07]
                    end else if (!state_q.lock_mask && req_in.wdata == conv_regs_pkg::LOCK_CODE_UNLOCK) begin
                        state_d.locked = 1'b0; // [R08]
                    end
                end
                conv_regs_pkg::VOLTAGE_SETTING_ADDR: begin
                    // a masked lock leaves the register always writable
                    if (!state_q.locked || state_q.lock_mask) begin
                        state_d.voltage_setting = req_in.wdata; // [R06] [R08]
                    end
                end
                default: begin
                end
            endcase
        end
        if (req_in.rd) begin
            state_d.rvalid = 1'b1;
            unique case (req_in.addr)
                conv_regs_pkg::CONVERTER_FLAGS_ADDR: begin
                    state_d.rdata = {6'h00, output_ok_flag, input_low_flag}; // [R01] [R02] [R09]
                end
                conv_regs_pkg::INTERRUPT_FLAGS_ADDR: begin
                    state_d.rdata = {6'h00, output_ok_irq, input_low_irq}; // [R03] [R04] [R09]
                end
                conv_regs_pkg::INTERRUPT_MASKS_ADDR: begin
                    state_d.rdata = {6'h00, state_q.irq_mask}; // [R05] [R09]
                end
                conv_regs_pkg::LOCK_PART_MASK_ADDR: begin
                    state_d.rdata = {7'h00, state_q.lock_mask}; // [R09]
                end
                conv_regs_pkg::LOCK_PASSWORD_ADDR: begin
                    state_d.rdata = state_q.lock_code; // [R07]
                end
                conv_regs_pkg::VOLTAGE_SETTING_ADDR: begin
                    state_d.rdata = state_q.voltage_setting;
                end
                default: begin
                    state_d.rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            state_q.irq_mask        <= conv_regs_pkg::IRQ_MASK_RESET;  // [R05]
            state_q.lock_mask       <= conv_regs_pkg::LOCK_MASK_RESET; // [R06]
            state_q.lock_code       <= conv_regs_pkg::LOCK_CODE_RESET; // [R07]
            state_q.locked          <= 1'b0;
            state_q.voltage_setting <= conv_regs_pkg::VOLTAGE_SETTING_RESET;
            state_q.rdata           <= 8'h00;
            state_q.rvalid          <= 1'b0;
            state_q.irq_n           <= 1'b1;
        end else if (clk_en_in) begin
            state_q <= state_d;
        end
    end

    assign rdata_out           = state_q.rdata;
    assign rvalid_out          = state_q.rvalid;
    assign voltage_setting_out = state_q.voltage_setting;
    assign voltage_locked_out  = state_q.locked;
    assign irq_n_out           = state_q.irq_n;
endmodule

// [sim/conv_regs_props.sv]
// Purpose: port checks for the converter register block
// Assumes: checks are suspended while reset or a frozen clock enable is seen
// Notes:   masks are seen only through read-back
`timescale 1ns/1ps
module conv_regs_props (
    input wire logic                     core_clk_in,
    input wire logic                     reset_in,
    input wire logic                     clk_en_in,
    input wire conv_regs_pkg::reg_req_t  req_in,
    input wire conv_regs_pkg::conv_cond_t cond_in,
    input wire logic [7:0]               rdata_out,
    input wire logic                     rvalid_out,
    input wire logic [7:0]               voltage_setting_out,
    input wire logic                     voltage_locked_out,
    input wire logic                     irq_n_out
);
    default clocking @(posedge core_clk_in); endclocking
    // a frozen cycle breaks the cycle counting of every property, so it aborts them
    default disable iff (reset_in || !clk_en_in);
    sequence wr_s(a); req_in.wr && req_in.addr == a; endsequence
    sequence rd_s(a); req_in.rd && !req_in.wr && req_in.addr == a; endsequence
    property rb_p(a, m); wr_s(a) ##2 rd_s(a) |=> rdata_out == ($past(req_in.wdata, 3) & m); endproperty
    status_read_a: assert property (rd_s(8'h05) |=> rdata_out == {6'h00, $past(cond_in, 2)})
        else $error("status read");
    irq_read_a: assert property (rd_s(8'h06) |=> rdata_out == {6'h00, $past(cond_in, 2)})
        else $error("flag read");
    mask_rb_a: assert property (rb_p(8'h07, 8'h03)) else $error("mask read-back");
    lock_mask_rb_a: assert property (rb_p(8'h50, 8'h01)) else $error("lock mask read-back");
    code_rb_a: assert property (rb_p(8'h51, 8'hFF)) else $error("code read-back");
    irq_cause_a: assert property (!irq_n_out |-> $past(cond_in, 2) != 2'h0) else $error("irq without flag");
    lock_cause_a: assert property ($rose(voltage_locked_out) |->
        $past(req_in.wr && req_in.addr == 8'h51 && req_in.wdata == 8'hAA)) else $error("lock without code");
    unlock_cause_a: assert property ($fell(voltage_locked_out) |->
        $past(req_in.wr && req_in.addr == 8'h51 && req_in.wdata == 8'h55)) else $error("unlock without code");
    volt_hold_a: assert property (req_in.wr && req_in.addr == 8'h02 && voltage_locked_out
        |=> $stable(voltage_setting_out)) else $error("locked setting changed");
    volt_write_a: assert property (req_in.wr && req_in.addr == 8'h02 && !voltage_locked_out
        |=> voltage_setting_out == $past(req_in.wdata)) else $error("setting write lost");
endmodule

// [sim/host_model.sv]
// Purpose: host side of the register port
// Assumes: one access at a time, strobes last one cycle
// Notes:   released address and data are inverted so stale values never look live
`timescale 1ns/1ps
module host_model (
    input  wire logic               core_clk_in,
    output conv_regs_pkg::reg_req_t req_out
);
    initial req_out = '0;
    task automatic access(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk_in);
        req_out = '{wr: w, rd: r, addr: a, wdata: d};
        @(negedge core_clk_in);
        req_out = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
endmodule

// [sim/tb_top.sv]
// Purpose: self-checking bench for the converter register block
// Assumes: clock enable high except in the freeze scenario at the end
// Notes:   read results are queued by the driver and checked on read valid
`timescale 1ns/1ps
module tb_top;
    logic                       core_clk_in, reset_in, clk_en_in, rvalid, locked, irq_n;
    conv_regs_pkg::reg_req_t    req;
    conv_regs_pkg::conv_cond_t  cond;
    logic [7:0]                 rdata, volt, v;
    logic [7:0]                 exp_q[$];
    int                         err_total, comparisons;
    host_model host_model_inst (.core_clk_in(core_clk_in), .req_out(req));
    converter_status_irq_lock_regs converter_status_irq_lock_regs_inst (.core_clk_in(core_clk_in),
        .reset_in(reset_in), .clk_en_in(clk_en_in), .req_in(req), .cond_in(cond), .rdata_out(rdata),
        .rvalid_out(rvalid), .voltage_setting_out(volt), .voltage_locked_out(locked), .irq_n_out(irq_n));
    initial begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end
    task automatic chk(input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("wrong value at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_model_inst.access(1'b1, 1'b0, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host_model_inst.access(1'b0, 1'b1, a, 8'h00);
    endtask
    task automatic test_done;
        if (err_total == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    always @(negedge core_clk_in) if (rvalid === 1'b1) chk(exp_q.pop_front(), rdata);
    initial begin
        #100000;
        err_total++;
        test_done();
    end
    initial begin
        reset_in = 1'b1;
        clk_en_in = 1'b1;
        cond = '0;
        void'($urandom(95));
        repeat (3) @(negedge core_clk_in);
        reset_in = 1'b0;
        rd(8'h07, 8'h00);
        rd(8'h50, 8'h01);
        rd(8'h51, 8'hFF);
        for (int i = 0; i < 16; i++) begin
            wr(8'h07, {6'h3F, i[3:2]});
            rd(8'h07, {6'h00, i[3:2]});
            cond = i[1:0];
            repeat (3) @(negedge core_clk_in);
            rd(8'h05, {6'h00, i[1:0]});
            rd(8'h06, {6'h00, i[1:0]});
            chk({7'h00, (i[1:0] & ~i[3:2]) == 2'h0}, {7'h00, irq_n});
        end
        wr(8'h05, 8'h00);
        rd(8'h05, 8'h03);
        rd(8'h33, 8'h00);
        v = 8'($urandom());
        wr(8'h02, v);
        chk(v, volt);
        wr(8'h51, 8'hAA);
        chk(8'h00, {7'h00, locked});
        wr(8'h50, 8'hFE);
        rd(8'h50, 8'h00);
        wr(8'h51, 8'hAA);
        wr(8'h02, ~v);
        chk(8'h01, {7'h00, locked});
        chk(v, volt);
        wr(8'h51, 8'h55);
        rd(8'h51, 8'h55);
        wr(8'h02, ~v);
        chk(8'h00, {7'h00, locked});
        chk(~v, volt);
        // a low clock enable must freeze the registers: these writes are lost
        clk_en_in = 1'b0;
        wr(8'h07, 8'h00);
        wr(8'h02, v);
        clk_en_in = 1'b1;
        @(negedge core_clk_in);
        chk(~v, volt);
        rd(8'h07, 8'h03);
        repeat (3) @(negedge core_clk_in);
        test_done();
    end
endmodule
bind converter_status_irq_lock_regs conv_regs_props conv_regs_props_inst (.core_clk_in(core_clk_in),
    .reset_in(reset_in), .clk_en_in(clk_en_in), .req_in(req_in), .cond_in(cond_in), .rdata_out(rdata_out),
    .rvalid_out(rvalid_out), .voltage_setting_out(voltage_setting_out),
    .voltage_locked_out(voltage_locked_out), .irq_n_out(irq_n_out));
